// ---- logic/tdd_bus_map.svh ----
// timing and width constants for the shared bus direction block
`ifndef TDD_BUS_MAP_SVH
`define TDD_BUS_MAP_SVH
`define TDD_BUS_WIDTH 10
`define TDD_CLK_PERIOD_PS 25000
`define TDD_TURN_TIME_PS 500000
`define TDD_TURN_CYCLES ((`TDD_TURN_TIME_PS) / (`TDD_CLK_PERIOD_PS))
`define TDD_TURN_CNT_W 5
`endif

// ---- logic/tdd_bus_pkg.sv ----
// types for the shared bus direction block
package tdd_bus_pkg;
   typedef enum logic [1:0] {st_rx, st_to_tx, st_tx, st_to_rx} dir_state_t;
endpackage

// ---- logic/tdd_word_if.sv ----
// valid/ready word carrier between buffer and top
`timescale 1ns/100ps
interface tdd_word_if #(parameter int W = 10);
   logic in_valid;
   logic in_ready;
   logic [W-1:0] in_data;
   logic out_valid;
   logic out_ready;
   logic [W-1:0] out_data;
   modport buf_side (input in_valid, output in_ready, input in_data, output out_valid, input out_ready,
      output out_data);
   modport user_side (output in_valid, input in_ready, output in_data, input out_valid, output out_ready,
      input out_data);
endinterface

// ---- logic/tdd_skid_buf.sv ----
// two-entry valid/ready buffer
`timescale 1ns/100ps
module tdd_skid_buf #(
   parameter int W = 10,
   parameter int DEPTH = 2
)(
   input wire logic i_clk,
   input wire logic i_reset,
   input wire logic i_flush,
   tdd_word_if.buf_side bus
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   logic [W-1:0] mem_reg [DEPTH];
   logic [AW-1:0] wr_reg;
   logic [AW-1:0] rd_reg;
   logic [AW:0] cnt_reg;
   logic push;
   logic pop;

   assign bus.in_ready = (cnt_reg != (AW+1)'(DEPTH));
   assign bus.out_valid = (cnt_reg != '0);
   assign bus.out_data = mem_reg[rd_reg];
   assign push = bus.in_valid && bus.in_ready;
   assign pop = bus.out_valid && bus.out_ready;

   always_ff @(posedge i_clk)
   begin
      if (push)
      begin
         mem_reg[wr_reg] <= bus.in_data;
      end
   end

   // flush drops stale words when the bus direction turns
   always_ff @(posedge i_clk)
   begin
      if (i_reset || i_flush)
      begin
         wr_reg <= '0;
         rd_reg <= '0;
         cnt_reg <= '0;
      end
      else
      begin
         if (push)
         begin
            wr_reg <= (wr_reg == AW'(DEPTH-1)) ? '0 : wr_reg + 1'b1;
         end
         if (pop)
         begin
            rd_reg <= (rd_reg == AW'(DEPTH-1)) ? '0 : rd_reg + 1'b1;
         end
         if (push && !pop)
         begin
            cnt_reg <= cnt_reg + 1'b1;
         end
         else if (pop && !push)
         begin
            cnt_reg <= cnt_reg - 1'b1;
         end
      end
   end

   property p_no_overflow;
      @(posedge i_clk) disable iff (i_reset)
      (cnt_reg == (AW+1)'(DEPTH)) |-> !bus.in_ready;
   endproperty
   a_no_overflow: assert property (p_no_overflow) else $error("buffer accepts while full");
endmodule

// ---- logic/tdd_bus_dir.sv ----
// direction control for the shared half-duplex converter data bus
`timescale 1ns/100ps
`include "tdd_bus_map.svh"
module tdd_bus_dir #(
   parameter int W = `TDD_BUS_WIDTH,
   parameter int TURN_CYCLES = `TDD_TURN_CYCLES
)(
   input wire logic i_clk,
   input wire logic i_reset,
   input wire logic i_tx_sel_pin,
   input wire logic i_use_serial,
   input wire logic i_serial_tx,
   input wire logic i_fast_mode,
   input wire logic i_rx_valid,
   output logic o_rx_ready,
   input wire logic [W-1:0] i_rx_word,
   input wire logic [W-1:0] i_bus_in,
   output logic [W-1:0] o_bus_out,
   output logic o_bus_oe_n,
   output logic o_tx_valid,
   output logic [W-1:0] o_tx_word,
   output logic o_tx_mode,
   output logic o_busy
);
   localparam int CW = `TDD_TURN_CNT_W;
   localparam logic [CW-1:0] TURN_LAST = CW'(TURN_CYCLES - 1);

   logic pin_meta_reg;
   logic pin_sync_reg;
   logic want_tx;
   logic flush;
   tdd_bus_pkg::dir_state_t state_reg;
   logic [CW-1:0] cnt_reg;
   logic bus_drive;
   logic tx_open;
   tdd_word_if #(.W(W)) rxw ();

   // pin arrives from the baseband's own timing, so it is synchronised first
   always_ff @(posedge i_clk)
   begin
      if (i_reset)
      begin
         pin_meta_reg <= 1'b0;
         pin_sync_reg <= 1'b0;
      end
      else
      begin
         pin_meta_reg <= i_tx_sel_pin;
         pin_sync_reg <= pin_meta_reg;
      end
   end

   assign want_tx = i_use_serial ? i_serial_tx : pin_sync_reg;

   // slow mode simply takes the same turn time; the counter bounds both modes, as i_fast_mode is not used here
   always_ff @(posedge i_clk)
   begin
      if (i_reset)
      begin
         state_reg <= tdd_bus_pkg::st_rx;
         cnt_reg <= '0;
      end
      else
      begin
         case (state_reg)
            tdd_bus_pkg::st_rx:
            begin
               cnt_reg <= '0;
               if (want_tx)
               begin
                  state_reg <= tdd_bus_pkg::st_to_tx;
               end
            end
            tdd_bus_pkg::st_to_tx:
            begin
               cnt_reg <= cnt_reg + 1'b1;
               if (!want_tx)
               begin
                  state_reg <= tdd_bus_pkg::st_rx;
               end
               else if (cnt_reg == TURN_LAST)
               begin
                  state_reg <= tdd_bus_pkg::st_tx;
               end
            end
            tdd_bus_pkg::st_tx:
            begin
               cnt_reg <= '0;
               if (!want_tx)
               begin
                  state_reg <= tdd_bus_pkg::st_to_rx;
               end
            end
            default:
            begin
               cnt_reg <= cnt_reg + 1'b1;
               if (want_tx)
               begin
                  state_reg <= tdd_bus_pkg::st_tx;
               end
               else if (cnt_reg == TURN_LAST)
               begin
                  state_reg <= tdd_bus_pkg::st_rx;
               end
            end
         endcase
      end
   end

   assign bus_drive = (state_reg == tdd_bus_pkg::st_rx);
   assign tx_open = (state_reg == tdd_bus_pkg::st_tx);
   assign flush = !bus_drive;

   // rx words buffered two deep; the flush while the bus is out of receive drops any word still held
   assign rxw.in_valid = i_rx_valid;
   assign rxw.in_data = i_rx_word;
   assign o_rx_ready = rxw.in_ready;
   assign rxw.out_ready = bus_drive;

   tdd_skid_buf #(.W(W), .DEPTH(2)) u_rx_buf (
      .i_clk(i_clk),
      .i_reset(i_reset),
      .i_flush(flush),
      .bus(rxw.buf_side)
   );

   // rx converter output stage onto the shared bus
   always_ff @(posedge i_clk)
   begin
      if (i_reset)
      begin
         o_bus_out <= '0;
         o_bus_oe_n <= 1'b1;
      end
      else
      begin
         o_bus_oe_n <= !bus_drive;
         if (bus_drive && rxw.out_valid)
         begin
            o_bus_out <= rxw.out_data;
         end
      end
   end

   // tx converter input capture, independent of the rx side
   always_ff @(posedge i_clk)
   begin
      if (i_reset)
      begin
         o_tx_valid <= 1'b0;
         o_tx_word <= '0;
      end
      else
      begin
         o_tx_valid <= tx_open;
         if (tx_open)
         begin
            o_tx_word <= i_bus_in;
         end
      end
   end

   assign o_tx_mode = tx_open;
   assign o_busy = (state_reg == tdd_bus_pkg::st_to_tx) || (state_reg == tdd_bus_pkg::st_to_rx);

   property p_no_drive_in_tx;
      @(posedge i_clk) disable iff (i_reset)
      (state_reg == tdd_bus_pkg::st_tx) |=> o_bus_oe_n;
   endproperty
   a_no_drive_in_tx: assert property (p_no_drive_in_tx) else $error("rx drivers on during transmit");

   property p_no_take_in_rx;
      @(posedge i_clk) disable iff (i_reset)
      (state_reg == tdd_bus_pkg::st_rx) |=> !o_tx_valid;
   endproperty
   a_no_take_in_rx: assert property (p_no_take_in_rx) else $error("tx path takes word in receive");

   // the turn counter bounds the changeover, so the check watches the counter instead of a long repeat
   property p_turn_time;
      @(posedge i_clk) disable iff (i_reset)
      (i_fast_mode && state_reg == tdd_bus_pkg::st_to_tx && want_tx && cnt_reg == TURN_LAST) |=> o_tx_mode;
   endproperty
   a_turn_time: assert property (p_turn_time) else $error("changeover not finished at turn count");

   property p_turn_bound;
      @(posedge i_clk) disable iff (i_reset)
      (state_reg == tdd_bus_pkg::st_to_tx || state_reg == tdd_bus_pkg::st_to_rx) |-> (cnt_reg <= TURN_LAST);
   endproperty
   a_turn_bound: assert property (p_turn_bound) else $error("turn counter past its last count");

   property p_select;
      @(posedge i_clk) disable iff (i_reset)
      (state_reg == tdd_bus_pkg::st_tx && !want_tx) |=> (state_reg == tdd_bus_pkg::st_to_rx);
   endproperty
   a_select: assert property (p_select) else $error("select ignored");

   property p_exclusive;
      @(posedge i_clk) disable iff (i_reset)
      !(o_tx_valid && !o_bus_oe_n);
   endproperty
   a_exclusive: assert property (p_exclusive) else $error("both directions active");

   property p_rx_indep;
      @(posedge i_clk) disable iff (i_reset)
      (bus_drive && rxw.out_valid) |=> (o_bus_out == $past(rxw.out_data));
   endproperty
   a_rx_indep: assert property (p_rx_indep) else $error("rx word not put on bus");

   property p_tx_capture;
      @(posedge i_clk) disable iff (i_reset)
      tx_open |=> (o_tx_word == $past(i_bus_in));
   endproperty
   a_tx_capture: assert property (p_tx_capture) else $error("tx word not captured");
endmodule

// ---- test/baseband_model.sv ----
// baseband partner that drives tx words on the shared bus
`timescale 1ns/100ps
module baseband_model (
   input wire logic i_clk,
   input wire logic i_tx_mode,
   input wire logic i_busy,
   output logic o_drive,
   output logic [9:0] o_word
);
   // released in receive and during changeovers, so it never fights the rx drivers
   assign o_drive = i_tx_mode & ~i_busy;
   initial o_word = 10'h3c1;
   // a new word every cycle it drives lets the bench tell each captured word apart
   always @(posedge i_clk)
      if (o_drive)
         o_word <= o_word + 10'h001;
endmodule

// ---- test/test_tdd_shared_bus_direction.sv ----
// self-checking bench for the shared bus direction block
`timescale 1ns/100ps
module test_tdd_shared_bus_direction;
   localparam int TC = 2;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic pin = 1'b0;
   logic use_ser = 1'b1;
   logic ser_tx = 1'b0;
   logic rx_valid = 1'b0;
   logic [9:0] rx_word = 10'h000;
   logic [9:0] last = 10'h000;
   logic [9:0] bus_out, tx_word, bb_word;
   logic rx_ready, oe_n, tx_valid, tx_mode, busy, drive;
   int n_fail = 0;
   int check_count = 0;
   int cyc = 0;
   // no pull on the bus: a floating bus shows the inverse of its last level
   wire logic [9:0] bus = !oe_n ? bus_out : drive ? bb_word : ~last;
   always #12.5 clk = ~clk;
   always @(posedge clk)
      last <= bus;
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         n_fail++;
         conclude();
      end
   end
   baseband_model i_bb (.i_clk(clk), .i_tx_mode(tx_mode), .i_busy(busy), .o_drive(drive), .o_word(bb_word));
   tdd_bus_dir #(.W(10), .TURN_CYCLES(TC)) i_dut (.i_clk(clk), .i_reset(rst), .i_tx_sel_pin(pin),
      .i_use_serial(use_ser), .i_serial_tx(ser_tx), .i_fast_mode(1'b1), .i_rx_valid(rx_valid),
      .o_rx_ready(rx_ready), .i_rx_word(rx_word), .i_bus_in(bus), .o_bus_out(bus_out), .o_bus_oe_n(oe_n),
      .o_tx_valid(tx_valid), .o_tx_word(tx_word), .o_tx_mode(tx_mode), .o_busy(busy));
   task automatic chk(input logic [9:0] got, input logic [9:0] exp);
      check_count++;
      if (got !== exp)
      begin
         n_fail++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic rx_word_test(input logic [9:0] w);
      int n;
      n = 0;
      @(posedge clk);
      rx_valid <= 1'b1;
      rx_word <= w;
      @(negedge clk);
      chk({9'h000, rx_ready}, 10'h001);
      @(posedge clk);
      rx_valid <= 1'b0;
      while (n < 8 && bus !== w)
      begin
         @(negedge clk);
         n++;
      end
      chk(bus, w);
      chk({9'h000, tx_valid}, 10'h000);
      $display("rx word test done");
   endtask
   task automatic turn(input logic ser, input logic tx, input int exp_n);
      int n;
      logic saw_busy;
      n = 0;
      saw_busy = 1'b0;
      @(posedge clk);
      use_ser <= ser;
      if (ser)
         ser_tx <= tx;
      else
         pin <= tx;
      do
      begin
         @(posedge clk);
         n++;
         #1;
         saw_busy = saw_busy | busy;
      end
      while ((tx ? tx_mode : ~oe_n) !== 1'b1 && n < 40);
      chk(10'(n), 10'(exp_n));
      chk({9'h000, saw_busy}, 10'h001);
      repeat (3) @(posedge clk);
      #1;
      chk({9'h000, busy}, 10'h000);
      if (tx)
      begin
         chk({9'h000, oe_n}, 10'h001);
         chk({9'h000, tx_valid}, 10'h001);
         chk(tx_word, bb_word - 10'h001);
      end
      else
         chk({9'h000, tx_valid}, 10'h000);
      $display("turn test done");
   endtask
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   initial
   begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rx_word_test(10'h2a5);
      turn(1'b1, 1'b1, TC + 1);
      turn(1'b1, 1'b0, TC + 2);
      rx_word_test(10'h15a);
      turn(1'b0, 1'b1, TC + 3);
      turn(1'b0, 1'b0, TC + 4);
      rx_word_test(10'h0f3);
      conclude();
   end
endmodule
